// File: pwet_timer.sv
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps

module pwet_timer (
   // Clock and reset.
   input  wire logic       SYS_CLK,
   input  wire logic       RSTN,
   // Register port.
   input  wire logic [1:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   output logic      [7:0] REG_RDATA,
   // Timer input pin.
   input  wire logic       TIMER_PIN,
   // Processor power-down status.
   input  wire logic       POWER_DOWN,
   // Interrupt and wake-up.
   output logic            TIMER_IRQ,
   output logic            WAKEUP
);
   logic [1:0]            div_count;
   logic                  insn_tick;
   logic                  pin_level;
   logic                  pin_rise;
   logic                  pin_fall;
   pwet_pkg::pwet_mode_t  mode;
   logic                  counter_run;
   logic                  edge_select;
   logic                  mode_select_high;
   logic                  mode_select_low;
   logic                  int_enable;
   logic                  int_flag;
   logic [15:0]           count;
   logic [15:0]           preload;
   logic [7:0]            low_buffer;
   logic [7:0]            read_latch;
   pwet_pkg::pwet_pw_state_t pw_state;
   logic                  wr_timer_low;
   logic                  wr_timer_high;
   logic                  wr_control;
   logic                  wr_int_ctrl;
   logic                  rd_timer_low;
   logic                  rd_timer_high;
   logic                  access_inhibit;
   logic                  start_edge;
   logic                  stop_edge;
   logic                  pw_done;
   logic                  count_step;
   logic                  overflow;
   logic [7:0]            next_rdata;

   // Pin conditioning shared by event and pulse modes.
   pwet_sync u_sync (
      .clk   (SYS_CLK),
      .rst_n (RSTN),
      .tick  (insn_tick),
      .pin   (TIMER_PIN),
      .level (pin_level),
      .rise  (pin_rise),
      .fall  (pin_fall)
   );

   // Instruction clock divider; it runs free, even in power-down, because
   // event counting samples the pin on its ticks.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         div_count <= 2'h0;
      end else begin
         div_count <= div_count + 2'h1;
      end
   end
   assign insn_tick = (div_count == pwet_pkg::DIV_LAST);

   // Address decode of the register port.
   assign wr_timer_low  = REG_WR & (REG_ADDR == pwet_pkg::OFS_TIMER_LOW);
   assign wr_timer_high = REG_WR & (REG_ADDR == pwet_pkg::OFS_TIMER_HIGH);
   assign wr_control    = REG_WR & (REG_ADDR == pwet_pkg::OFS_CONTROL);
   assign wr_int_ctrl   = REG_WR & (REG_ADDR == pwet_pkg::OFS_INT_CTRL);
   assign rd_timer_low  = REG_RD & (REG_ADDR == pwet_pkg::OFS_TIMER_LOW);
   assign rd_timer_high = REG_RD & (REG_ADDR == pwet_pkg::OFS_TIMER_HIGH);

   // Any counter read or preload write freezes counting for that cycle.
   // A step that falls in it is dropped, which software must tolerate.
   assign access_inhibit = rd_timer_low | rd_timer_high
                         | wr_timer_low | wr_timer_high;

   // Mode decode from the two select bits.
   assign mode = pwet_pkg::pwet_mode_t'({mode_select_high, mode_select_low});

   // Control register fields; the run bit is handled on its own below.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         mode_select_high <= pwet_pkg::CONTROL_RESET[pwet_pkg::BIT_MODE_HIGH];
         mode_select_low  <= pwet_pkg::CONTROL_RESET[pwet_pkg::BIT_MODE_LOW];
         edge_select      <= pwet_pkg::CONTROL_RESET[pwet_pkg::BIT_EDGE];
      end else if (wr_control) begin
         mode_select_high <= REG_WDATA[pwet_pkg::BIT_MODE_HIGH];
         mode_select_low  <= REG_WDATA[pwet_pkg::BIT_MODE_LOW];
         edge_select      <= REG_WDATA[pwet_pkg::BIT_EDGE];
      end
   end

   // Active edges for a pulse measurement: edge select low measures a low
   // pulse, high measures a high pulse. Only transitions count, so a pin
   // already at the active level when run is set does not start it.
   assign start_edge = edge_select ? pin_rise : pin_fall;
   assign stop_edge  = edge_select ? pin_fall : pin_rise;

   // Hardware end of a pulse measurement.
   assign pw_done = (mode == pwet_pkg::PWET_MODE_PULSE)
                  & (pw_state == pwet_pkg::PWET_PW_MEASURE) & stop_edge;

   // Run bit: software writes win; hardware clears it only when a pulse
   // measurement ends, never in timer or event mode.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         counter_run <= pwet_pkg::CONTROL_RESET[pwet_pkg::BIT_RUN];
      end else if (wr_control) begin
         counter_run <= REG_WDATA[pwet_pkg::BIT_RUN];
      end else if (pw_done) begin
         counter_run <= 1'b0;
      end
   end

   // Pulse measurement sequencer. Setting run once pulse mode is already selected arms it; the start edge
   // begins counting; the stop edge returns to idle, where further pin
   // activity is ignored until run is written high again.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pw_state <= pwet_pkg::PWET_PW_IDLE;
      end else if (mode != pwet_pkg::PWET_MODE_PULSE) begin
         pw_state <= pwet_pkg::PWET_PW_IDLE;
      end else if (wr_control) begin
         pw_state <= REG_WDATA[pwet_pkg::BIT_RUN] ? pwet_pkg::PWET_PW_ARMED
                                                   : pwet_pkg::PWET_PW_IDLE;
      end else begin
         case (pw_state)
            pwet_pkg::PWET_PW_IDLE: begin
               pw_state <= pwet_pkg::PWET_PW_IDLE;
            end
            pwet_pkg::PWET_PW_ARMED: begin
               if (start_edge) begin
                  pw_state <= pwet_pkg::PWET_PW_MEASURE;
               end
            end
            pwet_pkg::PWET_PW_MEASURE: begin
               if (stop_edge) begin
                  pw_state <= pwet_pkg::PWET_PW_IDLE;
               end
            end
            default: begin
               pw_state <= pwet_pkg::PWET_PW_IDLE;
            end
         endcase
      end
   end

   // Counting step per mode. Timer and pulse modes count instruction clock
   // ticks, which are gated off in power-down; event mode counts sampled pin edges
   // and keeps going in power-down.
   always_comb begin
      count_step = 1'b0;
      case (mode)
         pwet_pkg::PWET_MODE_TIMER: begin
            count_step = counter_run & insn_tick & ~POWER_DOWN;
         end
         pwet_pkg::PWET_MODE_EVENT: begin
            count_step = counter_run & (edge_select ? pin_fall : pin_rise);
         end
         pwet_pkg::PWET_MODE_PULSE: begin
            count_step = counter_run & insn_tick & ~POWER_DOWN
                       & (pw_state == pwet_pkg::PWET_PW_MEASURE) & ~stop_edge;
         end
         default: begin
            count_step = 1'b0;
         end
      endcase
      if (access_inhibit) begin
         count_step = 1'b0;
      end
   end

   // Overflow happens on the step taken from the full count.
   assign overflow = count_step & (count == pwet_pkg::COUNT_FULL);

   // Preload value: a high byte write moves the buffered low byte and the
   // new high byte into it in one go.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         preload    <= pwet_pkg::COUNT_RESET;
         low_buffer <= 8'h00;
      end else begin
         if (wr_timer_low) begin
            low_buffer <= REG_WDATA;
         end
         if (wr_timer_high) begin
            preload <= {REG_WDATA, low_buffer};
         end
      end
   end

   // Counter. A preload write reaches it at once only while stopped;
   // while running the new value waits for the next overflow reload.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         count <= pwet_pkg::COUNT_RESET;
      end else if (wr_timer_high && !counter_run) begin
         count <= {REG_WDATA, low_buffer};
      end else if (overflow) begin
         count <= preload;
      end else if (count_step) begin
         count <= count + 16'h0001;
      end
   end

   // A high byte read captures the low byte so the two halves agree.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         read_latch <= 8'h00;
      end else if (rd_timer_high) begin
         read_latch <= count[7:0];
      end
   end

   // Interrupt control: enable is software only; the request flag is set
   // by every overflow and an overflow in the same cycle beats a clear.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         int_enable <= 1'b0;
         int_flag   <= 1'b0;
      end else begin
         if (wr_int_ctrl) begin
            int_enable <= REG_WDATA[pwet_pkg::BIT_INT_ENABLE];
         end
         if (overflow) begin
            int_flag <= 1'b1;
         end else if (wr_int_ctrl) begin
            int_flag <= REG_WDATA[pwet_pkg::BIT_INT_FLAG];
         end
      end
   end

   // Interrupt request stays quiet unless enabled.
   assign TIMER_IRQ = int_flag & int_enable;

   // Wake-up ignores the enable. A flag that is already set masks it, which
   // is how software keeps an event counter from waking the device.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         WAKEUP <= 1'b0;
      end else begin
         WAKEUP <= overflow & POWER_DOWN & ~int_flag;
      end
   end

   // Read data mux; the answer appears in the cycle after the strobe.
   always_comb begin
      next_rdata = 8'h00;
      case (REG_ADDR)
         pwet_pkg::OFS_TIMER_LOW: begin
            next_rdata = read_latch;
         end
         pwet_pkg::OFS_TIMER_HIGH: begin
            next_rdata = count[15:8];
         end
         pwet_pkg::OFS_CONTROL: begin
            next_rdata[pwet_pkg::BIT_MODE_HIGH] = mode_select_high;
            next_rdata[pwet_pkg::BIT_MODE_LOW]  = mode_select_low;
            next_rdata[pwet_pkg::BIT_RUN]       = counter_run;
            next_rdata[pwet_pkg::BIT_EDGE]      = edge_select;
         end
         pwet_pkg::OFS_INT_CTRL: begin
            next_rdata[pwet_pkg::BIT_INT_ENABLE] = int_enable;
            next_rdata[pwet_pkg::BIT_INT_FLAG]   = int_flag;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // Read data register; it holds zero outside the answer cycle.
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         REG_RDATA <= next_rdata;
      end else begin
         REG_RDATA <= 8'h00;
      end
   end

   // The synchronised pin level itself is not needed beyond edge finding.
   logic unused_level;
   assign unused_level = pin_level;
endmodule // pwet_timer

// File: pwet_sync.sv
`timescale 1ns/1ps

// Shared constants for the pulse width / event timer.
package pwet_pkg;
   // Register offsets on the byte register port.
   localparam logic [1:0] OFS_TIMER_LOW  = 2'h0;
   localparam logic [1:0] OFS_TIMER_HIGH = 2'h1;
   localparam logic [1:0] OFS_CONTROL    = 2'h2;
   localparam logic [1:0] OFS_INT_CTRL   = 2'h3;
   // Control register field positions.
   localparam int BIT_MODE_HIGH = 7;
   localparam int BIT_MODE_LOW  = 6;
   localparam int BIT_RUN       = 4;
   localparam int BIT_EDGE      = 3;
   // Interrupt control register field positions.
   localparam int BIT_INT_ENABLE = 0;
   localparam int BIT_INT_FLAG   = 1;
   // Values after reset, and the full count from which the counter overflows.
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_FULL    = 16'hffff;
   // Instruction clock is the system clock divided by this many cycles.
   localparam int          INSN_DIV      = 4;
   localparam logic [1:0]  DIV_LAST      = 2'(INSN_DIV - 1);
   // Operating mode codes on the two mode select bits.
   typedef enum logic [1:0] {
      PWET_MODE_OFF   = 2'h0,
      PWET_MODE_EVENT = 2'h1,
      PWET_MODE_TIMER = 2'h2,
      PWET_MODE_PULSE = 2'h3
   } pwet_mode_t;
   // Pulse measurement states, Gray coded along idle, armed, measuring.
   typedef enum logic [1:0] {
      PWET_PW_IDLE    = 2'h0,
      PWET_PW_ARMED   = 2'h1,
      PWET_PW_MEASURE = 2'h3
   } pwet_pw_state_t;
endpackage

// Two-stage synchroniser for the timer pin, then a sample taken on each
// instruction clock tick; edges are the difference of successive samples.
module pwet_sync (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Instruction clock enable.
   input  wire logic tick,
   // Asynchronous pin.
   input  wire logic pin,
   // Synchronised level and edges, valid in the tick cycle.
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta;
   logic sync;

   // The first stage feeds only the second stage. Reset to the pin's idle
   // high level so no false edge follows reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b1;
         sync <= 1'b1;
      end else begin
         meta <= pin;
         sync <= meta;
      end
   end

   // Pin conditions are seen only at the next instruction clock tick.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level <= 1'b1;
      end else if (tick) begin
         level <= sync;
      end
   end

   // Edges compare the held sample with the current synchronised level.
   assign rise = tick & sync & ~level;
   assign fall = tick & ~sync & level;
endmodule // pwet_sync

// File: pwet_asserts.sv
`timescale 1ns/1ps

// Port-level checks; the count itself is judged by the bench through reads.
module pwet_asserts (
   // Clock and reset.
   input wire logic       SYS_CLK,
   input wire logic       RSTN,
   // Register port.
   input wire logic [1:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic       REG_WR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_RDATA,
   // Pin, power state and outputs.
   input wire logic       TIMER_PIN,
   input wire logic       POWER_DOWN,
   input wire logic       TIMER_IRQ,
   input wire logic       WAKEUP
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   chk_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 8'h00)
      else $error("read data not zero outside a read slot");
   chk_ctrl_resv: assert property (REG_RD && REG_ADDR == 2'h2 |=> REG_RDATA[5] == 1'b0 && REG_RDATA[2:0] == 3'h0)
      else $error("control spare bits read nonzero");
   chk_int_resv: assert property (REG_RD && REG_ADDR == 2'h3 |=> REG_RDATA[7:2] == 6'h00)
      else $error("interrupt control spare bits read nonzero");
   chk_irq_off: assert property (REG_WR && REG_ADDR == 2'h3 && !REG_WDATA[0] |=> !TIMER_IRQ)
      else $error("interrupt seen with enable cleared");
   chk_irq_on: assert property (REG_WR && REG_ADDR == 2'h3 && REG_WDATA[1:0] == 2'h3 |=> TIMER_IRQ)
      else $error("interrupt missing with flag and enable set");
   chk_wake_pd: assert property (WAKEUP |-> $past(POWER_DOWN))
      else $error("wake-up outside power-down");
   // Overflows can only come on instruction ticks, four clocks apart.
   chk_wake_space: assert property (WAKEUP |=> !WAKEUP [*3])
      else $error("wake-up pulses closer than one tick");
   // A flag already set by software must keep an overflow from waking.
   chk_wake_block: assert property ((REG_WR && REG_ADDR == 2'h3 && REG_WDATA[1])
      ##1 !(REG_WR && REG_ADDR == 2'h3) |=> !WAKEUP)
      else $error("wake-up while request flag set");
endmodule // pwet_asserts

bind pwet_timer pwet_asserts chk (.SYS_CLK, .RSTN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
   .REG_RDATA, .TIMER_PIN, .POWER_DOWN, .TIMER_IRQ, .WAKEUP);

// File: pwet_pin_src.sv
`timescale 1ns/1ps

// Pulse and event source on the timer pin, commanded by the bench.
module pwet_pin_src (
   // Clock used only to place pin changes.
   input wire logic clk,
   // Timer pin.
   output logic     pin
);
   // The pin idles high until a scenario moves it.
   initial pin = 1'b1;

   // Short levels could slip between ticks, so every level is held long enough.
   task automatic drive(input logic v, input int n);
      int k;
      k = (n < 8) ? 8 : n;
      @(posedge clk);
      pin <= v;
      repeat (k - 1) @(posedge clk);
   endtask
endmodule // pwet_pin_src

// File: tb_top.sv
`timescale 1ns/1ps

module tb_top;
   logic       SYS_CLK;
   logic       RSTN;
   logic [1:0] REG_ADDR;
   logic [7:0] REG_WDATA;
   logic       REG_WR;
   logic       REG_RD;
   logic [7:0] REG_RDATA;
   logic       TIMER_PIN;
   logic       POWER_DOWN;
   logic       TIMER_IRQ;
   logic       WAKEUP;
   int         error_cnt = 0;
   int         checks_done = 0;
   int         wake_cnt = 0;

   pwet_timer dut (.SYS_CLK, .RSTN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
      .TIMER_PIN, .POWER_DOWN, .TIMER_IRQ, .WAKEUP);
   pwet_pin_src src (.clk(SYS_CLK), .pin(TIMER_PIN));

   // Free-running 50 MHz clock.
   initial begin
      SYS_CLK = 1'b0;
      forever #10 SYS_CLK = ~SYS_CLK;
   end

   // Count wake-up pulses, each seen at the edge after it rises.
   always @(posedge SYS_CLK) begin
      if (WAKEUP === 1'b1) wake_cnt++;
   end

   task automatic conclude;
      if (error_cnt == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Pin timing is only seen at ticks, so measured counts get a window.
   task automatic rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      checks_done++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [15:0] v);
      @(posedge SYS_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1;
      v = {8'h00, REG_RDATA};
   endtask

   // High byte first so the low byte is latched from the same count.
   task automatic rd16(output logic [15:0] v);
      logic [15:0] h;
      logic [15:0] l;
      rd(2'h1, h);
      rd(2'h0, l);
      v = {h[7:0], l[7:0]};
   endtask

   task automatic set16(input logic [15:0] v);
      wr(2'h0, v[7:0]);
      wr(2'h1, v[15:8]);
   endtask

   task automatic t_reset;
      logic [15:0] v;
      rd(2'h2, v);
      chk(v, 16'h0000);
      rd(2'h3, v);
      chk(v, 16'h0000);
      rd16(v);
      chk(v, 16'h0000);
   endtask

   task automatic t_bytes;
      logic [15:0] v;
      set16(16'h1234);
      rd16(v);
      chk(v, 16'h1234);
      wr(2'h0, 8'h56);
      rd16(v);
      chk(v, 16'h1234);
   endtask

   task automatic t_timer;
      logic [15:0] v;
      wr(2'h3, 8'h00);
      set16(16'hfff8);
      wr(2'h2, 8'h80);
      wr(2'h2, 8'h90);
      set16(16'h1000);
      rd16(v);
      rng(v, 16'hfff8, 16'hffff);
      repeat (60) @(posedge SYS_CLK);
      rd16(v);
      rng(v, 16'h1000, 16'h1010);
      rd(2'h3, v);
      chk(v, 16'h0002);
      chk({15'h0000, TIMER_IRQ}, 16'h0000);
      wr(2'h3, 8'h03);
      rd(2'h2, v);
      chk(v, 16'h0090);
      chk({15'h0000, TIMER_IRQ}, 16'h0001);
      wr(2'h3, 8'h00);
      wr(2'h2, 8'h80);
   endtask

   // Arm with the pin already active, then a real pulse, then a late one.
   task automatic t_pulse(input logic e);
      logic [15:0] v;
      logic [15:0] w;
      logic [7:0]  c;
      c = 8'hc0 | {4'h0, e, 3'h0};
      set16(16'h0000);
      src.drive(e, 8);
      wr(2'h2, c);
      wr(2'h2, c | 8'h10);
      src.drive(e, 40);
      rd16(v);
      chk(v, 16'h0000);
      src.drive(~e, 40);
      rd(2'h2, v);
      chk(v, {8'h00, c | 8'h10});
      src.drive(e, 120);
      src.drive(~e, 20);
      rd(2'h2, v);
      chk(v, {8'h00, c});
      rd16(w);
      rng(w, 16'd28, 16'd31);
      src.drive(e, 40);
      src.drive(~e, 20);
      rd16(v);
      chk(v, w);
      wr(2'h2, 8'h80);
   endtask

   task automatic t_event;
      logic [15:0] v;
      wr(2'h2, 8'h40);
      set16(16'hfffc);
      wr(2'h3, 8'h00);
      src.drive(1'b0, 8);
      wr(2'h2, 8'h50);
      POWER_DOWN <= 1'b1;
      repeat (4) begin
         src.drive(1'b1, 8);
         src.drive(1'b0, 8);
      end
      chk(16'(wake_cnt), 16'h0001);
      rd(2'h3, v);
      chk(v, 16'h0002);
      wr(2'h3, 8'h02);
      repeat (4) begin
         src.drive(1'b1, 8);
         src.drive(1'b0, 8);
      end
      chk(16'(wake_cnt), 16'h0001);
      rd16(v);
      chk(v, 16'hfffc);
      POWER_DOWN <= 1'b0;
      wr(2'h2, 8'h40);
      set16(16'h0000);
      wr(2'h2, 8'h48);
      wr(2'h2, 8'h58);
      repeat (3) begin
         src.drive(1'b1, 8);
         src.drive(1'b0, 8);
      end
      rd16(v);
      chk(v, 16'h0003);
      wr(2'h2, 8'h00);
   endtask

   // A hung run counts as a mismatch.
   initial begin
      #2ms;
      error_cnt++;
      conclude();
   end

   // Reset, then the scenarios in turn.
   initial begin
      RSTN = 1'b0;
      REG_ADDR = 2'h0;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      POWER_DOWN = 1'b0;
      repeat (20) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      t_reset();
      t_bytes();
      t_timer();
      t_pulse(1'b0);
      t_pulse(1'b1);
      t_event();
      conclude();
   end
endmodule // tb_top
